// >>> design/tpg_pkg.sv
// Package: register map, field layout and constants of the pulse generator
package tpg_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'hF90;
  localparam logic [11:0] ADDR_MODULO_HIGH_REG = 12'hF94;
  localparam logic [11:0] ADDR_MODULO_LOW_REG = 12'hF96;

  // --------------------------------------------------------------
  // Reset values and masks
  // --------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODULO_HIGH_REG_RST = 8'h00;
  localparam logic [7:0] MODULO_LOW_REG_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hBB; // Bits 2 and 6 stay zero
  localparam logic [7:0] MODULO_LOW_REG_RMASK = 8'hFC; // Low two bits read zero

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int BIT_RELOAD = 3;
  localparam int PRE_SEL_LSB = 2;
  localparam int PRE_SEL_N = 5;
  localparam int MODULO_LOW_REG_FINE_LSB = 2;

  // --------------------------------------------------------------
  // Modes and timing
  // --------------------------------------------------------------
  localparam logic MODE_PWM = 1'b0;
  localparam logic MODE_TIMER = 1'b1;
  localparam logic [7:0] PRE_MAX = 8'hFF; // Divide by 256 terminal
  localparam int LATCH_W = 14;
  localparam int PWM_CNT_W = 15;        // Sub period of 2^15 clocks
  localparam int PWM_FRAME_LSB = 10;    // Fundamental period 2^10 clocks
  localparam int PWM_COARSE_W = 9;
  localparam int PWM_FINE_W = 5;

  // Control register layout
  typedef struct packed {
    logic pin_en;
    logic unused6;
    logic src;
    logic static_lvl;
    logic reload;
    logic zero2;
    logic run;
    logic mode;
  } tpg_ctrl_t;

endpackage

// >>> design/tpg_pwm.sv
// PWM core: 14-bit low-width waveform and fixed-interval event
`timescale 1ns/1ns
module tpg_pwm
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic en,
  input wire logic [tpg_pkg::LATCH_W-1:0] latch,
  output logic pwm_o,
  output logic period_o
);

  logic [tpg_pkg::PWM_CNT_W-1:0] cnt_r;
  logic [tpg_pkg::PWM_COARSE_W-1:0] coarse_r;
  logic extra_r;
  logic frame_start;
  logic [tpg_pkg::PWM_COARSE_W-1:0] pos;
  logic [tpg_pkg::PWM_FINE_W-1:0] frame;
  logic [tpg_pkg::PWM_COARSE_W:0] low_w;
  logic low;
  logic wrap;

  // --------------------------------------------------------------
  // Phase decode: half-rate step inside each fundamental frame
  // --------------------------------------------------------------
  assign pos = cnt_r[tpg_pkg::PWM_FRAME_LSB-1:1];
  assign frame = cnt_r[tpg_pkg::PWM_CNT_W-1:tpg_pkg::PWM_FRAME_LSB];
  assign frame_start = (cnt_r[tpg_pkg::PWM_FRAME_LSB-1:0] == '0);
  assign wrap = (cnt_r == '1);
  // Frames below the fine value get one extra low step
  assign low_w = {1'b0, coarse_r} + {{tpg_pkg::PWM_COARSE_W{1'b0}}, extra_r};
  assign low = ({1'b0, pos} < low_w);

  // Latch is sampled once per frame so faster rewrites have no effect
  always_ff @(posedge clk)
  begin
    if (!reset_n || !en)
    begin
      cnt_r <= '0;
      coarse_r <= '0;
      extra_r <= 1'b0;
      pwm_o <= 1'b1;
      period_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      if (frame_start)
      begin
        coarse_r <= latch[tpg_pkg::LATCH_W-1:tpg_pkg::PWM_FINE_W];
        extra_r <= (frame < latch[tpg_pkg::PWM_FINE_W-1:0]);
      end
      pwm_o <= ~low;
      period_o <= wrap;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_pwm_period: assert property (@(posedge clk) disable iff (!reset_n)
    (en && wrap) |=> period_o)
    else $error("PWM period event missing");

  a_pwm_idle_high: assert property (@(posedge clk) disable iff (!reset_n)
    !en |=> (pwm_o && !period_o))
    else $error("PWM not idle high when disabled");

endmodule

// >>> design/tpg_top.sv
// Top: timer and pulse generator with control and modulo registers
//
// Summary of operation
// - Mode bit 0 selects PWM generation, 1 selects the interval timer.
// - Run bit 0 stops all counting; 1 lets the generator operate.
// - Reload bit 3 gates modulo copy to latch; writable alone.
// - Static bit sets the pin level when static output is chosen.
// - Source bit 0 routes static bit, 1 routes generated waveform.
// - Pin enable 0 floats the pin, 1 drives it.
// - Reset clears the control register: stopped, pin disabled.
// - Control register is 8 bits at F90H; bit 2 zero, bit 6 unused.
// - Timer mode is an 8-bit interval timer setting the event flag.
// - One-hot low modulo bits 2..6 pick divide 256 down to 16.
// - Timer interval is divisor times high modulo plus one clocks.
// - Square wave frequency is clock over twice divisor times N plus one.
// - Counting begins on the rising edge of the run bit.
// - PWM mode outputs a 14-bit resolution waveform.
// - PWM mode sets the event flag every 2^15 clocks.
// - Latch is high modulo over low modulo upper six bits.
// - PWM is active low, low width is latch over 2^14.
`timescale 1ns/1ns
module tpg_top
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [11:0] ADDR,
  input wire logic WR_EN,
  input wire logic [7:0] WDATA,
  input wire logic BIT_WR,
  input wire logic BIT_DATA,
  input wire logic RD_EN,
  output logic [7:0] RDATA,
  input wire logic IRQ_CLR,
  output logic IRQ_FLAG,
  output logic PULSE_OUT,
  output logic PULSE_OE
);

  tpg_pkg::tpg_ctrl_t ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] modulo_high_reg_r;
  logic [7:0] modulo_low_reg_r;
  logic [tpg_pkg::LATCH_W-1:0] latch_r;
  logic [7:0] pre_r;
  logic [7:0] cnt_r;
  logic sq_r;
  logic [7:0] pre_mask;
  logic [7:0] part_mask [tpg_pkg::PRE_SEL_N];
  logic sel_ctrl;
  logic sel_modulo_high_reg;
  logic sel_modulo_low_reg;
  logic timer_act;
  logic pwm_act;
  logic tick;
  logic match;
  logic pwm_lvl;
  logic pwm_evt;
  logic irq_set;
  logic gen_lvl;
  logic [7:0] rd_mux;

  // --------------------------------------------------------------
  // Address decode and control write data
  // --------------------------------------------------------------
  assign sel_ctrl = (ADDR == tpg_pkg::ADDR_CTRL);
  assign sel_modulo_high_reg = (ADDR == tpg_pkg::ADDR_MODULO_HIGH_REG);
  assign sel_modulo_low_reg = (ADDR == tpg_pkg::ADDR_MODULO_LOW_REG);

  // Byte write wins over a single-bit write of the reload bit
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (WR_EN && sel_ctrl)
      ctrl_nxt = WDATA & tpg_pkg::CTRL_WMASK;
    else if (BIT_WR && sel_ctrl)
      ctrl_nxt[tpg_pkg::BIT_RELOAD] = BIT_DATA;
  end

  // Register storage
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ctrl_r <= tpg_pkg::CTRL_RST;
      modulo_high_reg_r <= tpg_pkg::MODULO_HIGH_REG_RST;
      modulo_low_reg_r <= tpg_pkg::MODULO_LOW_REG_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      if (WR_EN && sel_modulo_high_reg)
        modulo_high_reg_r <= WDATA;
      if (WR_EN && sel_modulo_low_reg)
        modulo_low_reg_r <= WDATA;
    end
  end

  // Reload: high modulo and upper six bits of low modulo copied into the latch when enabled
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      latch_r <= '0;
    else if (ctrl_r.reload)
      latch_r <= {modulo_high_reg_r, modulo_low_reg_r[7:tpg_pkg::MODULO_LOW_REG_FINE_LSB]};
  end

  // --------------------------------------------------------------
  // Readback
  // --------------------------------------------------------------
  assign rd_mux = sel_ctrl ? ctrl_r :
                  sel_modulo_high_reg ? modulo_high_reg_r :
                  sel_modulo_low_reg ? (modulo_low_reg_r & tpg_pkg::MODULO_LOW_REG_RMASK) : 8'h00;

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      RDATA <= 8'h00;
    else
      RDATA <= RD_EN ? rd_mux : 8'h00;
  end

  // --------------------------------------------------------------
  // Prescaler select: one mask per one-hot select bit
  // --------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < tpg_pkg::PRE_SEL_N; gi++)
    begin : g_pre
      assign part_mask[gi] =
        latch_r[tpg_pkg::PRE_SEL_LSB - tpg_pkg::MODULO_LOW_REG_FINE_LSB + gi] ?
        (tpg_pkg::PRE_MAX >> gi) : 8'h00;
    end
  endgenerate

  assign pre_mask = part_mask[0] | part_mask[1] | part_mask[2] |
                    part_mask[3] | part_mask[4];

  // --------------------------------------------------------------
  // Interval timer
  // --------------------------------------------------------------
  assign timer_act = ctrl_r.run &&
    (ctrl_r.mode == tpg_pkg::MODE_TIMER);
  assign pwm_act = ctrl_r.run &&
    (ctrl_r.mode == tpg_pkg::MODE_PWM);
  assign tick = timer_act && ((pre_r & pre_mask) == pre_mask);
  // Compare against the high modulo half of the latch
  assign match = tick &&
    (cnt_r == latch_r[tpg_pkg::LATCH_W-1:tpg_pkg::LATCH_W-8]);

  // Counters sit at zero while stopped, so a run rising edge starts fresh
  always_ff @(posedge CLK)
  begin
    if (!RESET_N || !timer_act)
    begin
      pre_r <= 8'h00;
      cnt_r <= 8'h00;
      sq_r <= 1'b0;
    end
    else
    begin
      pre_r <= tick ? 8'h00 : pre_r + 8'h01;
      if (match)
        cnt_r <= 8'h00;
      else if (tick)
        cnt_r <= cnt_r + 8'h01;
      if (match)
        sq_r <= ~sq_r;
    end
  end

  // --------------------------------------------------------------
  // PWM core
  // --------------------------------------------------------------
  tpg_pwm u_pwm
  (
    .clk(CLK),
    .reset_n(RESET_N),
    .en(pwm_act),
    .latch(latch_r),
    .pwm_o(pwm_lvl),
    .period_o(pwm_evt)
  );

  // --------------------------------------------------------------
  // Event flag and output pin
  // --------------------------------------------------------------
  assign irq_set = match || pwm_evt;
  assign gen_lvl = ctrl_r.mode ? sq_r : pwm_lvl;

  // Set beats clear in the same cycle
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      IRQ_FLAG <= 1'b0;
    else if (irq_set)
      IRQ_FLAG <= 1'b1;
    else if (IRQ_CLR)
      IRQ_FLAG <= 1'b0;
  end

  // Pin level and drive enable
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      PULSE_OUT <= 1'b0;
      PULSE_OE <= 1'b0;
    end
    else
    begin
      PULSE_OUT <= ctrl_r.src ? gen_lvl : ctrl_r.static_lvl;
      PULSE_OE <= ctrl_r.pin_en;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_timer_match;
    match ##1 IRQ_FLAG;
  endsequence

  a_reset_clears_ctrl: assert property (disable iff (1'b0)
    !RESET_N |=> (ctrl_r == 8'h00 && !PULSE_OE))
    else $error("Reset did not clear control");

  a_ctrl_fixed_bits: assert property (!ctrl_r.zero2 && !ctrl_r.unused6)
    else $error("Fixed control bits not zero");

  a_pin_float: assert property (!ctrl_r.pin_en |=> !PULSE_OE)
    else $error("Pin driven while disabled");

  a_static_level: assert property (
    (!ctrl_r.src && $stable(ctrl_r)) |=>
    (PULSE_OUT == $past(ctrl_r.static_lvl)))
    else $error("Static level not on pin");

  // Both counters must restart from zero on the next run edge
  a_stop_idle: assert property (
    !ctrl_r.run |=> (cnt_r == 8'h00 && pre_r == 8'h00))
    else $error("Counter active while stopped");

  a_match_flags: assert property (match |-> s_timer_match)
    else $error("Timer match did not set flag");

  a_sq_toggle: assert property (match |=> (sq_r != $past(sq_r)))
    else $error("Square wave did not toggle");

  a_reload_hold: assert property (!ctrl_r.reload |=> $stable(latch_r))
    else $error("Latch changed with reload off");

  a_reload_copy: assert property (ctrl_r.reload |=>
    (latch_r == {$past(modulo_high_reg_r), $past(modulo_low_reg_r[7:2])}))
    else $error("Latch not loaded from modulo");

  a_set_wins: assert property ((irq_set && IRQ_CLR) |=> IRQ_FLAG)
    else $error("Flag clear beat a set");

  a_tick_spacing: assert property (
    (tick && timer_act && latch_r[0]) |=> !tick [*8])
    else $error("Prescaler tick too early");

endmodule

// >>> tb/tpg_pin_load.sv
// Partner model: external load hanging on the pulse output pin
`timescale 1ns/1ns
module tpg_pin_load
(
  input wire logic clk,
  input wire logic drv,
  input wire logic oe,
  output logic pin
);
  logic last_r;

  // Remember the level last driven onto the pin
  always_ff @(posedge clk)
  begin
    if (oe)
      last_r <= drv;
  end

  // No pull on the wire, so a floating pin shows the inverse of its last level
  // Released pin reads as the inverse of what was last driven
  assign pin = oe ? drv : ~last_r;
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the timer and pulse generator
`timescale 1ns/1ns
module tb_top;
  logic CLK, RESET_N, WR_EN, BIT_WR, BIT_DATA, RD_EN, IRQ_CLR, p;
  logic [11:0] ADDR;
  logic [7:0] WDATA, RDATA, rd_v, h, l, d;
  logic IRQ_FLAG, PULSE_OUT, PULSE_OE, pin;
  int mismatches, samples_checked, lows, n, k;

  tpg_top DUT (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WR_EN(WR_EN),
    .WDATA(WDATA), .BIT_WR(BIT_WR), .BIT_DATA(BIT_DATA), .RD_EN(RD_EN),
    .RDATA(RDATA), .IRQ_CLR(IRQ_CLR), .IRQ_FLAG(IRQ_FLAG),
    .PULSE_OUT(PULSE_OUT), .PULSE_OE(PULSE_OE));
  tpg_pin_load LOAD (.clk(CLK), .drv(PULSE_OUT), .oe(PULSE_OE), .pin(pin));

  // --------------------------------------------------------------
  // Expectations and checking
  // --------------------------------------------------------------
  function automatic int tmr_period(int i, int nv);
    return (256 >> i) * (nv + 1);
  endfunction
  function automatic int pwm_low(logic [7:0] hv, logic [7:0] lv);
    return 2 * int'({hv, lv[7:2]});
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Register port and event flag tasks, driven at falling edges
  // --------------------------------------------------------------
  task automatic wr(logic [11:0] a, logic [7:0] v);
    @(negedge CLK);
    ADDR = a;
    WDATA = v;
    WR_EN = 1'b1;
    @(negedge CLK);
    WR_EN = 1'b0;
  endtask
  task automatic bw(logic b);
    @(negedge CLK);
    ADDR = tpg_pkg::ADDR_CTRL;
    BIT_DATA = b;
    BIT_WR = 1'b1;
    @(negedge CLK);
    BIT_WR = 1'b0;
  endtask
  task automatic rd(logic [11:0] a);
    @(negedge CLK);
    ADDR = a;
    RD_EN = 1'b1;
    @(negedge CLK);
    RD_EN = 1'b0;
    rd_v = RDATA;
  endtask
  task automatic wait_flag(int lim);
    k = 0;
    while (IRQ_FLAG !== 1'b1 && k < lim)
    begin
      @(negedge CLK);
      k++;
      lows += (pin === 1'b0);
    end
  endtask
  task automatic clr();
    IRQ_CLR = 1'b1;
    @(negedge CLK);
    IRQ_CLR = 1'b0;
    lows += (pin === 1'b0);
  endtask

  // Free-running clock
  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // Watchdog against a hung run
  initial
  begin
    #380000;
    mismatches++;
    final_report();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    {RESET_N, WR_EN, BIT_WR, BIT_DATA, RD_EN, IRQ_CLR} = 6'h00;
    ADDR = 12'h000;
    WDATA = 8'h00;
    void'($urandom(32'hC626D836));
    repeat (4) @(negedge CLK);
    RESET_N = 1'b1;
    // Reset state and fixed bits
    rd(tpg_pkg::ADDR_CTRL);
    chk("ctrl reset", rd_v, 8'h00);
    chk("oe reset", PULSE_OE, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      wr(tpg_pkg::ADDR_CTRL, d);
      rd(tpg_pkg::ADDR_CTRL);
      chk("ctrl readback", rd_v, d & 8'hBB);
    end
    rd(12'hF91);
    chk("unmapped read", rd_v, 8'h00);
    // Single-bit reload access
    wr(tpg_pkg::ADDR_CTRL, 8'h00);
    bw(1'b1);
    rd(tpg_pkg::ADDR_CTRL);
    chk("reload set", rd_v, 8'h08);
    bw(1'b0);
    rd(tpg_pkg::ADDR_CTRL);
    chk("reload clear", rd_v, 8'h00);
    // Static output levels and pin release
    for (int i = 0; i < 2; i++)
    begin
      wr(tpg_pkg::ADDR_CTRL, 8'h80 | 8'(i << 4));
      repeat (2) @(negedge CLK);
      chk("static level", pin, i[0]);
      chk("pin driven", PULSE_OE, 1'b1);
    end
    wr(tpg_pkg::ADDR_CTRL, 8'h10);
    repeat (2) @(negedge CLK);
    chk("pin released", PULSE_OE, 1'b0);
    chk("pin floats", pin, 1'b0);
    // Drop any flag left by the random control phase
    clr();
    // Timer mode with every prescaler code
    for (int i = 0; i < 5; i++)
    begin
      n = $urandom_range(3, 1);
      wr(tpg_pkg::ADDR_MODULO_HIGH_REG, 8'(n));
      wr(tpg_pkg::ADDR_MODULO_LOW_REG, 8'h04 << i);
      wr(tpg_pkg::ADDR_CTRL, 8'hA9);
      wr(tpg_pkg::ADDR_CTRL, 8'hAB);
      wait_flag(3000);
      clr();
      p = pin;
      wait_flag(3000);
      chk("timer interval", k + 1, tmr_period(i, n));
      @(negedge CLK);
      chk("square toggle", pin, {~p});
      wr(tpg_pkg::ADDR_CTRL, 8'hA9);
      clr();
    end
    // A stopped generator raises no events
    wait_flag(600);
    chk("stopped flag", IRQ_FLAG, 1'b0);
    // PWM mode: low time over one sub period and event spacing
    h = 8'($urandom_range(255, 1));
    l = 8'($urandom);
    wr(tpg_pkg::ADDR_MODULO_HIGH_REG, h);
    wr(tpg_pkg::ADDR_MODULO_LOW_REG, l);
    rd(tpg_pkg::ADDR_MODULO_LOW_REG);
    chk("modulo_low_reg readback", rd_v, l & 8'hFC);
    rd(tpg_pkg::ADDR_MODULO_HIGH_REG);
    chk("modulo_high_reg readback", rd_v, h);
    wr(tpg_pkg::ADDR_CTRL, 8'hA8);
    wr(tpg_pkg::ADDR_CTRL, 8'hAA);
    wait_flag(40000);
    lows = 0;
    clr();
    wait_flag(40000);
    chk("pwm event interval", k + 1, 32768);
    chk("pwm low time", lows, pwm_low(h, l));
    final_report();
  end
endmodule
